// file: design/charger_defines.svh
// Constants for the charger safety and fault supervisor
`ifndef CHARGER_DEFINES_SVH
`define CHARGER_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define REG_CTRL_STATUS   8'h00
`define REG_CTRL          8'h01
`define REG_VOLTAGE       8'h02
`define REG_IDENT         8'h03
`define REG_CURRENT       8'h04
`define REG_SPECIAL       8'h05
`define REG_LIMIT_LOCK    8'h06

// ----------------------------------------------------------------------
// Reset values (defaults used at power-on and on reload)
// ----------------------------------------------------------------------
`define CTRL_RESET        8'h00
`define VOLTAGE_RESET     6'h02
`define CURRENT_RESET     8'h00
`define SPECIAL_RESET     8'h00
`define LIMIT_LOCK_RESET  7'h00
`define IDENT_VALUE       8'h5A

// ----------------------------------------------------------------------
// Field codes and encodings
// ----------------------------------------------------------------------
`define ILIM_100MA        2'b00
`define ILIM_NONE         2'b11
`define STAT_READY        2'b00
`define STAT_CHARGING     2'b01
`define STAT_DONE         2'b10
`define STAT_FAULT        2'b11
`define FAULT_NONE        3'b000
`define FAULT_VBUS_OVP    3'b001
`define FAULT_SLEEP       3'b010
`define FAULT_POOR_INPUT  3'b011
`define FAULT_BAT_OVP     3'b100
`define FAULT_THERMAL     3'b101
`define FAULT_NO_BATTERY  3'b111
`define VCAP_BASE_CODE    6'h23
`define VREG_TOP_CODE     6'h2F
`define SENSE_LOWEST_STEP 3'h0

// ----------------------------------------------------------------------
// Timing: printed times and the clock rate they are converted with
// ----------------------------------------------------------------------
`define CLK_FREQ_KHZ      40000
`define RETRY_TIME_MS     2000
`define PWM_STALL_TIME_MS 30
`define SOFT_START_TIME_MS 1
`define DETECT_TIME_MS    500
`define STAT_PULSE_TIME_US 128

`endif

// file: design/charger_pkg.sv
// Types shared by the charger safety and fault supervisor
package charger_pkg;

  // Supervisor sequencing states
  typedef enum logic [3:0] {
    ST_WAIT_VALID,
    ST_CHARGE,
    ST_THERMAL,
    ST_SLEEP,
    ST_UV_RETRY,
    ST_OVP,
    ST_BAT_OVP,
    ST_DETECT,
    ST_DONE,
    ST_NOBAT_RETRY
  } sup_state_e;

endpackage

// file: design/stat_pulse_gen.sv
// One-shot stretcher that turns a fault event into a fixed-width status pulse
`timescale 1ns/1ps

module stat_pulse_gen #(
  parameter int unsigned PULSE_CYCLES = 5120
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic trigger,
  output logic      pulseOut
);

  logic [31:0] cnt_r;

  // A new trigger during a pulse restarts the full width
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_r    <= 32'h0000_0000;
      pulseOut <= 1'b0;
    end else if (trigger) begin
      cnt_r    <= PULSE_CYCLES - 32'h0000_0001;
      pulseOut <= 1'b1;
    end else if (cnt_r != 32'h0000_0000) begin
      cnt_r    <= cnt_r - 32'h0000_0001;
    end else begin
      pulseOut <= 1'b0;
    end
  end

endmodule

// file: design/charger_safety_fault_supervisor.sv
// Charger limit lock register, code clamping and fault sequencing
//
// Overview of operation
// - Charge voltage or current writes above the cap are stored as the cap.
// - Past short threshold the cap register reloads default, writable until another write.
// - Any other register write locks the cap register until battery drops below short.
// - Cap register holds current cap in bits 6:4 and voltage cap in 3:0.
// - Voltage cap code n allows charge voltage code 100011 plus n.
// - Current cap codes use the same eight sense steps as charge current.
// - Die foldback flag forces the lowest sense step regardless of programming.
// - Shutdown temperature suspends charging, sets fault 101, pulses status.
// - Thermal suspend freezes timers and state, resumes below foldback.
// - Input below battery plus sleep margin, above first threshold: sleep, block reverse.
// - Input below second threshold while charging: stop, pulse, status 11, fault 011.
// - After undervoltage wait retry interval, then restart if input above first threshold.
// - Input overvoltage: blocking switch off, suspend; while charging also fault 001, status 11, pulse; the code acts on it only in wait-valid and charge states.
// - Overvoltage clears when input drops back; resume only after revalidation.
// - With end-of-charge enable zero, no switching pulses for 30 ms: fault 100, status 11, pulse.
// - Termination with end-of-charge on: stop, status 10, detect discharge, fault 000.
// - Battery falling during detect: defaults reloaded, fault 111, retry after interval.
// - After power-on charge with default parameters until the host writes.
// - Raising voltage, input limit or current codes starts 1 ms soft-start.
// - Host sets constant-voltage flag without battery; device clears it on insertion.
// - Fault code reported in bits 2:0 of the control and status register.
// - Termination and battery detection only while end-of-charge enable is one.
// - Input limit code decodes 00 100 mA, 01 500, 10 800, 11 none.
`timescale 1ns/1ps
`include "charger_defines.svh"

module charger_safety_fault_supervisor #(
  parameter int unsigned RETRY_CYCLES  = `RETRY_TIME_MS * `CLK_FREQ_KHZ,
  parameter int unsigned STALL_CYCLES  = `PWM_STALL_TIME_MS * `CLK_FREQ_KHZ,
  parameter int unsigned SOFT_CYCLES   = `SOFT_START_TIME_MS * `CLK_FREQ_KHZ,
  parameter int unsigned DETECT_CYCLES = `DETECT_TIME_MS * `CLK_FREQ_KHZ,
  parameter int unsigned STAT_CYCLES   = (`STAT_PULSE_TIME_US * `CLK_FREQ_KHZ) / 1000
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Register port from the serial interface engine
  input  wire logic       regWrEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  // Comparator and pin levels, asynchronous to sys_clk
  input  wire logic       tempFoldback,
  input  wire logic       tempShutdown,
  input  wire logic       vbusAboveMin1,
  input  wire logic       vbusBelowMin2,
  input  wire logic       vbusBelowBatSleep,
  input  wire logic       vbusOvp,
  input  wire logic       vbusValid,
  input  wire logic       vbatAboveShort,
  input  wire logic       vbatAboveRecharge,
  input  wire logic       vbatNearReg,
  input  wire logic       termCurrentReached,
  input  wire logic       pwmPulse,
  input  wire logic       batteryInserted,
  // Controls to the power stage
  output logic            chargeEnable,
  output logic            blockingSwitchOn,
  output logic            reverseBlock,
  output logic      [2:0] senseStep,
  output logic      [5:0] voltageCodeOut,
  output logic      [1:0] inputLimitOut,
  output logic            softStartActive,
  output logic            detectDischarge,
  output logic            timersHalt,
  output logic            statPin
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  localparam int NSYNC = 13;
  logic [NSYNC-1:0] syncA_r;
  logic [NSYNC-1:0] syncB_r;
  logic             pwmDly_r;
  logic             shortDly_r;
  logic             batInsDly_r;
  wire              sTFold;
  wire              sTShut;
  wire              sMin1;
  wire              sMin2;
  wire              sSleepCmp;
  wire              sOvp;
  wire              sValid;
  wire              sShort;
  wire              sRecharge;
  wire              sNearReg;
  wire              sTermI;
  wire              sPwm;
  wire              sBatIns;

  // First stage feeds only the second one; all logic reads syncB_r
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else begin
      syncA_r <= {tempFoldback, tempShutdown, vbusAboveMin1, vbusBelowMin2,
                  vbusBelowBatSleep, vbusOvp, vbusValid, vbatAboveShort,
                  vbatAboveRecharge, vbatNearReg, termCurrentReached,
                  pwmPulse, batteryInserted};
      syncB_r <= syncA_r;
    end
  end

  assign {sTFold, sTShut, sMin1, sMin2, sSleepCmp, sOvp, sValid, sShort,
          sRecharge, sNearReg, sTermI, sPwm, sBatIns} = syncB_r;

  // Edge history for pulse-style inputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwmDly_r    <= 1'b0;
      shortDly_r  <= 1'b0;
      batInsDly_r <= 1'b0;
    end else begin
      pwmDly_r    <= sPwm;
      shortDly_r  <= sShort;
      batInsDly_r <= sBatIns;
    end
  end

  wire pwmEdge    = sPwm & ~pwmDly_r;
  wire shortRise  = sShort & ~shortDly_r;
  wire batInsRise = sBatIns & ~batInsDly_r;

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [1:0] statCode_r;
  logic [2:0] faultCode_r;
  logic [7:0] ctrl_r;
  logic [5:0] voltCode_r;
  logic [1:0] voltLow_r;
  logic [7:0] curr_r;
  logic [7:0] special_r;
  logic [6:0] limit_r;
  logic       limitWritable_r;

  wire [1:0] ilimCode   = ctrl_r[7:6];
  wire       endEnable  = ctrl_r[3];
  wire [2:0] chgCurCode = curr_r[6:4];
  wire [2:0] curCap     = limit_r[6:4];
  wire [3:0] voltCap    = limit_r[3:0];
  wire [5:0] voltCapCode = `VCAP_BASE_CODE + {2'b00, voltCap};

  // Write decode
  wire wrCtrlStat = regWrEn & (regAddr == `REG_CTRL_STATUS);
  wire wrCtrl     = regWrEn & (regAddr == `REG_CTRL);
  wire wrVolt     = regWrEn & (regAddr == `REG_VOLTAGE);
  wire wrCurr     = regWrEn & (regAddr == `REG_CURRENT);
  wire wrSpecial  = regWrEn & (regAddr == `REG_SPECIAL);
  wire wrLimit    = regWrEn & (regAddr == `REG_LIMIT_LOCK);
  wire wrOther    = regWrEn & (regAddr != `REG_LIMIT_LOCK);

  // Clamp incoming codes against the caps
  wire [5:0] wrVoltCode = regWrData[7:2];
  wire [2:0] wrCurCode  = regWrData[6:4];
  wire [5:0] voltClamped = (wrVoltCode > voltCapCode) ? voltCapCode : wrVoltCode;
  wire [2:0] curClamped  = (wrCurCode > curCap) ? curCap : wrCurCode;

  // Raising any of the three codes requests soft-start
  wire raiseVolt = wrVolt & (voltClamped > voltCode_r);
  wire raiseCur  = wrCurr & (curClamped > chgCurCode);
  wire raiseIlim = wrCtrl & (regWrData[7:6] > ilimCode);
  wire ssStart   = raiseVolt | raiseCur | raiseIlim;

  // ----------------------------------------------------------------------
  // Fault sequencer
  // ----------------------------------------------------------------------
  charger_pkg::sup_state_e state_r;
  charger_pkg::sup_state_e state_nxt;
  logic [31:0] stCnt_r;
  logic        faultSet;
  logic [2:0]  faultVal;
  logic        statSet;
  logic [1:0]  statVal;
  logic        pulseReq;
  logic        loadDefaults;

  // Next state and the register side effects of each transition
  always_comb begin
    state_nxt    = state_r;
    faultSet     = 1'b0;
    faultVal     = `FAULT_NONE;
    statSet      = 1'b0;
    statVal      = `STAT_READY;
    pulseReq     = 1'b0;
    loadDefaults = 1'b0;
    case (state_r)
      charger_pkg::ST_WAIT_VALID: begin
        if (sOvp) begin
          state_nxt = charger_pkg::ST_OVP;
        end else if (sValid) begin
          state_nxt = charger_pkg::ST_CHARGE;
          statSet   = 1'b1;
          statVal   = `STAT_CHARGING;
        end
      end
      charger_pkg::ST_CHARGE: begin
        if (sOvp) begin
          state_nxt = charger_pkg::ST_OVP;
          faultSet  = 1'b1;
          faultVal  = `FAULT_VBUS_OVP;
          statSet   = 1'b1;
          statVal   = `STAT_FAULT;
          pulseReq  = 1'b1;
        end else if (sTShut) begin
          state_nxt = charger_pkg::ST_THERMAL;
          faultSet  = 1'b1;
          faultVal  = `FAULT_THERMAL;
          pulseReq  = 1'b1;
        end else if (sMin2) begin
          state_nxt = charger_pkg::ST_UV_RETRY;
          faultSet  = 1'b1;
          faultVal  = `FAULT_POOR_INPUT;
          statSet   = 1'b1;
          statVal   = `STAT_FAULT;
          pulseReq  = 1'b1;
        end else if (sSleepCmp && sMin1) begin
          state_nxt = charger_pkg::ST_SLEEP;
          faultSet  = 1'b1;
          faultVal  = `FAULT_SLEEP;
        end else if (endEnable && sNearReg && sTermI) begin
          state_nxt = charger_pkg::ST_DETECT;
          statSet   = 1'b1;
          statVal   = `STAT_DONE;
        end else if (!endEnable && stCnt_r >= STALL_CYCLES - 1) begin
          state_nxt = charger_pkg::ST_BAT_OVP;
          faultSet  = 1'b1;
          faultVal  = `FAULT_BAT_OVP;
          statSet   = 1'b1;
          statVal   = `STAT_FAULT;
          pulseReq  = 1'b1;
        end
      end
      charger_pkg::ST_THERMAL: begin
        if (!sTShut && !sTFold) begin
          state_nxt = charger_pkg::ST_CHARGE;
        end
      end
      charger_pkg::ST_SLEEP: begin
        if (!(sSleepCmp && sMin1)) begin
          state_nxt = charger_pkg::ST_WAIT_VALID;
        end
      end
      charger_pkg::ST_UV_RETRY: begin
        if (stCnt_r >= RETRY_CYCLES - 1 && sMin1) begin
          state_nxt = charger_pkg::ST_WAIT_VALID;
        end
      end
      charger_pkg::ST_OVP: begin
        if (!sOvp) begin
          state_nxt = charger_pkg::ST_WAIT_VALID;
        end
      end
      charger_pkg::ST_BAT_OVP: begin
        if (pwmEdge) begin
          state_nxt = charger_pkg::ST_CHARGE;
        end
      end
      charger_pkg::ST_DETECT: begin
        if (stCnt_r >= DETECT_CYCLES - 1) begin
          faultSet = 1'b1;
          if (sRecharge) begin
            state_nxt = charger_pkg::ST_DONE;
            faultVal  = `FAULT_NONE;
          end else begin
            state_nxt    = charger_pkg::ST_NOBAT_RETRY;
            faultVal     = `FAULT_NO_BATTERY;
            loadDefaults = 1'b1;
          end
        end
      end
      charger_pkg::ST_DONE: begin
        if (!sRecharge) begin
          state_nxt = charger_pkg::ST_WAIT_VALID;
        end
      end
      charger_pkg::ST_NOBAT_RETRY: begin
        if (stCnt_r >= RETRY_CYCLES - 1) begin
          state_nxt = charger_pkg::ST_WAIT_VALID;
        end
      end
      default: begin
        state_nxt = charger_pkg::ST_WAIT_VALID;
      end
    endcase
  end

  // State timer: frozen while thermally suspended, restarted by pulses in charge
  wire stEnter   = (state_nxt != state_r);
  wire cntClear  = stEnter | ((state_r == charger_pkg::ST_CHARGE) & pwmEdge);
  wire cntFreeze = (state_r == charger_pkg::ST_THERMAL);

  // Power-on reset lands in charge with defaults, no validation wait
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= charger_pkg::ST_CHARGE;
      stCnt_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      if (cntClear) begin
        stCnt_r <= 32'h0000_0000;
      end else if (!cntFreeze && stCnt_r != 32'hFFFF_FFFF) begin
        stCnt_r <= stCnt_r + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register updates
  // ----------------------------------------------------------------------
  // Hardware fault and status updates win over a host write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      statCode_r  <= `STAT_CHARGING;
      faultCode_r <= `FAULT_NONE;
    end else begin
      if (statSet) begin
        statCode_r <= statVal;
      end else if (wrCtrlStat) begin
        statCode_r <= regWrData[5:4];
      end
      if (faultSet) begin
        faultCode_r <= faultVal;
      end
    end
  end

  // Host-programmed registers; the defaults reload leaves the cap alone
  always_ff @(posedge sys_clk) begin
    if (rst || loadDefaults) begin
      ctrl_r    <= `CTRL_RESET;
      voltCode_r <= `VOLTAGE_RESET;
      voltLow_r <= 2'b00;
      curr_r    <= `CURRENT_RESET;
      special_r <= `SPECIAL_RESET;
    end else begin
      if (wrCtrl) begin
        ctrl_r <= regWrData;
      end
      if (wrVolt) begin
        voltCode_r <= voltClamped;
        voltLow_r  <= regWrData[1:0];
      end
      if (wrCurr) begin
        curr_r <= {regWrData[7], curClamped, regWrData[3:0]};
      end
      if (batInsRise) begin
        special_r[3] <= 1'b0;
      end else if (wrSpecial) begin
        special_r <= regWrData;
      end
    end
  end

  // Cap register and its lock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      limit_r         <= `LIMIT_LOCK_RESET;
      limitWritable_r <= 1'b1;
    end else if (!sShort || shortRise) begin
      limit_r         <= shortRise ? `LIMIT_LOCK_RESET : limit_r;
      limitWritable_r <= 1'b1;
    end else if (wrOther) begin
      limitWritable_r <= 1'b0;
    end else if (wrLimit && limitWritable_r) begin
      limit_r <= regWrData[6:0];
    end
  end

  // Soft-start window counter
  logic [31:0] ssCnt_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ssCnt_r <= 32'h0000_0000;
    end else if (ssStart) begin
      ssCnt_r <= SOFT_CYCLES;
    end else if (ssCnt_r != 32'h0000_0000) begin
      ssCnt_r <= ssCnt_r - 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [7:0] rdMux;
  always_comb begin
    case (regAddr)
      `REG_CTRL_STATUS: rdMux = {2'b00, statCode_r, 1'b0, faultCode_r};
      `REG_CTRL:        rdMux = ctrl_r;
      `REG_VOLTAGE:     rdMux = {voltCode_r, voltLow_r};
      `REG_IDENT:       rdMux = `IDENT_VALUE;   // Arbitrary identity value
      `REG_CURRENT:     rdMux = curr_r;
      `REG_SPECIAL:     rdMux = special_r;
      `REG_LIMIT_LOCK:  rdMux = {1'b0, limit_r};
      default:          rdMux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // Power stage controls
  // ----------------------------------------------------------------------
  wire charging  = (state_r == charger_pkg::ST_CHARGE);
  wire [5:0] vEff = (voltCode_r > `VREG_TOP_CODE) ? `VREG_TOP_CODE : voltCode_r;
  wire [2:0] iEff = sTFold ? `SENSE_LOWEST_STEP : chgCurCode;
  wire ssOn      = (ssCnt_r != 32'h0000_0000);
  wire [1:0] ilimEff = (ssOn && ilimCode != `ILIM_NONE) ? `ILIM_100MA : ilimCode;

  // All top outputs are registered to keep them glitch-free at the pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdData        <= 8'h00;
      chargeEnable     <= 1'b0;
      blockingSwitchOn <= 1'b0;
      reverseBlock     <= 1'b0;
      senseStep        <= `SENSE_LOWEST_STEP;
      voltageCodeOut   <= `VOLTAGE_RESET;
      inputLimitOut    <= `ILIM_100MA;
      softStartActive  <= 1'b0;
      detectDischarge  <= 1'b0;
      timersHalt       <= 1'b0;
    end else begin
      regRdData        <= rdMux;
      chargeEnable     <= charging;
      blockingSwitchOn <= (state_r != charger_pkg::ST_OVP);
      reverseBlock     <= (state_r == charger_pkg::ST_SLEEP);
      senseStep        <= iEff;
      voltageCodeOut   <= vEff;
      inputLimitOut    <= ilimEff;
      softStartActive  <= ssOn;
      detectDischarge  <= (state_r == charger_pkg::ST_DETECT);
      timersHalt       <= (state_r == charger_pkg::ST_THERMAL);
    end
  end

  // Status pin stretcher for fault events
  stat_pulse_gen #(
    .PULSE_CYCLES (STAT_CYCLES)
  ) uStatPulse (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .trigger  (pulseReq),
    .pulseOut (statPin)
  );

endmodule

// file: verification/host_model.sv
// Host side of the register byte port
`timescale 1ns/1ps
module host_model (
  input  wire logic       sys_clk,
  output logic            regWrEn,
  output logic      [7:0] regWrData
);
  // Launch after the falling edge, hold across one rising edge
  task automatic wr(input logic [7:0] d);
    @(negedge sys_clk);
    regWrEn = 1'b1;
    regWrData = d;
    @(negedge sys_clk);
    regWrEn = 1'b0;
    regWrData = ~d; // Stale data must never look valid
  endtask
  initial begin
    regWrEn = 1'b0;
    regWrData = 8'h00;
  end
endmodule

// file: verification/charger_supervisor_monitor.sv
// Port assertions for the charger supervisor
`timescale 1ns/1ps
module charger_supervisor_monitor (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       tempFoldback,
  input wire logic       vbusOvp,
  input wire logic       chargeEnable,
  input wire logic       blockingSwitchOn,
  input wire logic       reverseBlock,
  input wire logic [2:0] senseStep,
  input wire logic [5:0] voltageCodeOut,
  input wire logic [1:0] inputLimitOut,
  input wire logic       softStartActive,
  input wire logic       timersHalt,
  input wire logic       statPin
);
  // One clock domain, so clock and reset are given once
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  fold_step_a: assert property (tempFoldback[*4] |=> senseStep == 3'h0)
    else $error("sense step not lowest in foldback");
  therm_stat_a: assert property ($rose(timersHalt) |-> ##[0:2] statPin)
    else $error("no status pulse on thermal suspend");
  stat_width_a: assert property ($rose(statPin) |-> statPin[*8] ##1 !statPin)
    else $error("status pulse width wrong");
  ovp_off_a: assert property ($rose(vbusOvp) && chargeEnable ##1 vbusOvp[*3]
    |-> ##[1:2] !blockingSwitchOn)
    else $error("blocking switch left on in overvoltage");
  ovp_idle_a: assert property (!blockingSwitchOn |-> !chargeEnable)
    else $error("charging with blocking switch off");
  sleep_rev_a: assert property (reverseBlock |-> !chargeEnable)
    else $error("charging while asleep");
  volt_cap_a: assert property (voltageCodeOut <= 6'h2F)
    else $error("voltage code above top cap");
  soft_lim_a: assert property (softStartActive[*2]
    |-> inputLimitOut inside {2'b00, 2'b11})
    else $error("input limit not lowered in soft start");
  cover property ($rose(statPin));
  cover property ($rose(softStartActive));
  cover property (!blockingSwitchOn);
endmodule
bind charger_safety_fault_supervisor charger_supervisor_monitor u_mon (.sys_clk, .rst,
  .tempFoldback, .vbusOvp, .chargeEnable, .blockingSwitchOn, .reverseBlock, .senseStep,
  .voltageCodeOut, .inputLimitOut, .softStartActive, .timersHalt, .statPin);

// file: verification/tb_top.sv
// Self-checking bench for the charger supervisor
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk, rst, regWrEn, rdPend, chargeEnable, statPin;
  logic        tempFoldback, tempShutdown, vbusAboveMin1, vbusBelowMin2, vbusOvp;
  logic        vbusValid, vbatAboveShort;
  logic        sleepCmp, rechg, nearReg, termI, batIns, dischg, revBlk;
  logic [2:0]  sense;
  logic [1:0]  ilimOut;
  logic        pwmPulse = 1'b0;
  logic [7:0]  regAddr, regWrData, regRdData;
  logic [5:0]  c, vcode;
  logic [15:0] e;
  logic [15:0] expQ[$];
  int          mismatches, num_checks;
  host_model u_host (.sys_clk(sys_clk), .regWrEn(regWrEn), .regWrData(regWrData));
  charger_safety_fault_supervisor #(.RETRY_CYCLES(200), .STALL_CYCLES(100),
    .SOFT_CYCLES(20), .DETECT_CYCLES(50), .STAT_CYCLES(8)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .tempFoldback(tempFoldback),
    .tempShutdown(tempShutdown), .vbusAboveMin1(vbusAboveMin1),
    .vbusBelowMin2(vbusBelowMin2), .vbusBelowBatSleep(sleepCmp), .vbusOvp(vbusOvp),
    .vbusValid(vbusValid), .vbatAboveShort(vbatAboveShort), .vbatAboveRecharge(rechg),
    .vbatNearReg(nearReg), .termCurrentReached(termI), .pwmPulse(pwmPulse),
    .batteryInserted(batIns), .chargeEnable(chargeEnable), .blockingSwitchOn(),
    .reverseBlock(revBlk), .senseStep(sense), .voltageCodeOut(vcode), .inputLimitOut(ilimOut),
    .softStartActive(), .detectDischarge(dischg), .timersHalt(), .statPin(statPin));
  // 40 MHz clock; switching pulses keep the stall detector quiet
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial forever begin
    repeat (4) @(negedge sys_clk);
    pwmPulse = ~pwmPulse;
  end
  task automatic check(input string nm, input logic [7:0] seen, exp, m);
    num_checks++;
    if ((seen & m) !== (exp & m)) begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", nm, exp & m, seen & m);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    regAddr = a;
    u_host.wr(d);
  endtask
  // Reads note the expected byte and mask; the posedge block below compares
  task automatic rd(input logic [7:0] a, exp, m);
    @(negedge sys_clk);
    regAddr = a;
    rdPend = 1'b1;
    expQ.push_back({m, exp});
    @(negedge sys_clk);
    rdPend = 1'b0;
  endtask
  task automatic wait_stat();
    int n;
    n = 0;
    while (statPin !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 20) begin
      mismatches++;
      print_verdict();
    end
  endtask
  // Read data is registered, so look just after the edge
  always @(posedge sys_clk) if (rdPend === 1'b1) begin
    #1;
    e = expQ.pop_front();
    check("regRdData", regRdData, e[7:0], e[15:8]);
  end
  initial begin
    void'($urandom(32'hdad2_2dd7));
    {regAddr, rdPend, tempFoldback, tempShutdown, vbusBelowMin2, vbusOvp} = '0;
    {sleepCmp, nearReg, termI, batIns} = 4'h0;
    {vbatAboveShort, rechg} = 2'b01;
    vbusAboveMin1 = 1'b1;
    vbusValid = 1'b1;
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    vbatAboveShort = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(8'h06, 8'h00, 8'h7F);
    wr(8'h06, 8'h25);
    wr(8'h06, 8'h25);
    rd(8'h06, 8'h25, 8'h7F);
    wr(8'h02, 8'hFD);
    rd(8'h02, 8'hA1, 8'hFF);
    wr(8'h04, 8'h70);
    rd(8'h04, 8'h20, 8'h70);
    wr(8'h06, 8'h77);
    rd(8'h06, 8'h25, 8'h7F);
    rd(8'h09, 8'h00, 8'hFF);
    for (int i = 0; i < 6; i++) begin
      c = 6'($urandom_range(63));
      wr(8'h02, {c, 2'b00});
      rd(8'h02, {(c > 6'h28) ? 6'h28 : c, 2'b00}, 8'hFC);
    end
    $display("test cap register done");
    tempFoldback = 1'b1;
    repeat (8) @(negedge sys_clk);
    check("senseStep", {5'h00, sense}, 8'h00, 8'h07);
    tempShutdown = 1'b1;
    wait_stat();
    rd(8'h00, 8'h05, 8'h07);
    {tempFoldback, tempShutdown} = 2'b00;
    repeat (10) @(negedge sys_clk);
    check("senseStep", {5'h00, sense}, 8'h02, 8'h07);
    $display("test thermal done");
    vbusBelowMin2 = 1'b1;
    vbusAboveMin1 = 1'b0;
    wait_stat();
    rd(8'h00, 8'h33, 8'h37);
    vbusBelowMin2 = 1'b0;
    vbusAboveMin1 = 1'b1;
    repeat (220) @(negedge sys_clk);
    $display("test undervoltage done");
    vbusOvp = 1'b1;
    vbusValid = 1'b0;
    wait_stat();
    rd(8'h00, 8'h31, 8'h37);
    vbusOvp = 1'b0;
    repeat (6) @(negedge sys_clk);
    check("chargeEnable", {7'h00, chargeEnable}, 8'h00, 8'h01);
    vbusValid = 1'b1;
    repeat (6) @(negedge sys_clk);
    check("chargeEnable", {7'h00, chargeEnable}, 8'h01, 8'h01);
    $display("test overvoltage done");
    vbatAboveShort = 1'b0;
    repeat (4) @(negedge sys_clk);
    vbatAboveShort = 1'b1;
    repeat (4) @(negedge sys_clk);
    wr(8'h06, 8'h7F);
    wr(8'h01, 8'hC0);
    wr(8'h02, 8'hFC);
    wr(8'h05, 8'h08);
    wr(8'h04, 8'h70);
    wr(8'h01, 8'h40);
    rd(8'h02, 8'hC8, 8'hFC);
    check("voltageCodeOut", {2'b00, vcode}, 8'h2F, 8'h3F);
    wr(8'h01, 8'h88);
    @(negedge sys_clk);
    check("inputLimitOut", {6'h00, ilimOut}, 8'h00, 8'h03);
    repeat (30) @(negedge sys_clk);
    check("inputLimitOut", {6'h00, ilimOut}, 8'h02, 8'h03);
    rd(8'h05, 8'h08, 8'h08);
    batIns = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(8'h05, 8'h00, 8'h08);
    $display("test start-up done");
    sleepCmp = 1'b1;
    repeat (5) @(negedge sys_clk);
    check("reverseBlock", {7'h00, revBlk}, 8'h01, 8'h01);
    rd(8'h00, 8'h02, 8'h07);
    sleepCmp = 1'b0;
    repeat (6) @(negedge sys_clk);
    {nearReg, termI} = 2'b11;
    repeat (6) @(negedge sys_clk);
    check("detectDischarge", {7'h00, dischg}, 8'h01, 8'h01);
    rd(8'h00, 8'h22, 8'h37);
    repeat (60) @(negedge sys_clk);
    rd(8'h00, 8'h20, 8'h37);
    rechg = 1'b0;
    repeat (70) @(negedge sys_clk);
    rd(8'h00, 8'h07, 8'h07);
    rd(8'h01, 8'h00, 8'hFF);
    repeat (210) @(negedge sys_clk);
    check("chargeEnable", {7'h00, chargeEnable}, 8'h01, 8'h01);
    $display("test battery detect done");
    print_verdict();
  end
endmodule
